// ===== logic/rwc_top.sv
// Reset sequencer, reset cause recording, watchdog and temperature restart
//
// Function
// - Load PC from vector, high byte first
// - Interrupt mask set on reset
// - Peripherals off, pins input, no pull-ups
// - Seven reset sources accepted
// - Cause bits; debug unrecorded; periodic elsewhere
// - Watchdog overflow forces system reset
// - Write-once option register enables watchdog
// - Write to cause register clears watchdog
// - Clock select: 0 slow oscillator, 1 bus
// - Slow clock counts 2^5 to 2^11
// - Bus clock counts 2^13 to 2^19
// - Watchdog enabled with defaults after reset
// - Watchdog halts in debug and stop
// - Cleared entering stop, resumes after 3
// - High threshold field in bits 6:4
// - Bit 0 shows outside range; restart
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "rwc_defs.svh"

module rwc_top #(
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources and modes
  input wire rwc_pkg::rwc_cause_type cause_req,
  input wire logic bdm_active,
  input wire logic stop_mode,
  input wire logic bus_tick,
  input wire logic slow_clk_pin,
  input wire logic temp_outside_pin,
  // Vector fetch port, data one cycle after vec_rd
  output logic [15:0] vec_addr,
  output logic vec_rd,
  input wire logic [7:0] vec_rdata,
  // Core and pad control
  output logic sys_reset,
  output logic cpu_run,
  output rwc_pkg::rwc_boot_type boot
);
  import rwc_pkg::*;

  localparam logic [3:0] HOLD_CYC = `RWC_RESET_HOLD;
  localparam logic [7:0] OPT_DEF = `RWC_OPT_RESET;

  // Overflow exponent; code 7 repeats code 6
  function automatic logic [4:0] ovf_exp(input logic clks,
                                         input logic [2:0] t);
    logic [4:0] base;
    logic [2:0] tt;
    base = clks ? `RWC_EXP_BUS_BASE : `RWC_EXP_SLOW_BASE;
    tt = (t == 3'h7) ? 3'h6 : t;
    ovf_exp = base + {2'h0, tt};
  endfunction : ovf_exp

  function automatic logic addr_is(input logic [31:0] a,
                                   input logic [15:0] idx);
    addr_is = (a == {14'h0, idx, 2'h0});
  endfunction : addr_is

  // Synchronisers for pins
  logic slow_s1, slow_s2, slow_s3;
  logic tout_s1, tout_s2;
  always_ff @(posedge clk) begin
    slow_s1 <= slow_clk_pin;
    slow_s2 <= slow_s1;
    slow_s3 <= slow_s2;
    tout_s1 <= temp_outside_pin;
    tout_s2 <= tout_s1;
  end
  logic slow_tick;
  assign slow_tick = slow_s2 & ~slow_s3;

  // Registers
  rwc_state_type state;
  logic [3:0] hold_cnt;
  logic [7:0] reset_cause;
  logic [7:0] sys_opt;
  logic opt_locked;
  logic periodic_reset_flag;
  logic temp_restart_enable;
  logic [7:0] temp_reg;
  logic tout_d;
  logic [CNT_W-1:0] wd_cnt;
  logic wd_clks;
  logic [2:0] wd_t;
  logic [1:0] resume_cnt;
  logic stop_d;

  // APB strobes
  logic acc, wr_stb;
  assign acc = psel & penable;
  assign wr_stb = acc & pready & pwrite;
  logic wr_cause, wr_opt, wr_wcs, wr_temp;
  assign wr_cause = wr_stb & addr_is(paddr, `RWC_IDX_RESET_CAUSE);
  assign wr_opt = wr_stb & addr_is(paddr, `RWC_IDX_SYS_OPT_ONE);
  assign wr_wcs = wr_stb & addr_is(paddr, `RWC_IDX_WAKE_CS_ONE);
  assign wr_temp = wr_stb & addr_is(paddr, `RWC_IDX_TEMP_RESTART);

  // Watchdog tick and overflow
  logic wd_en, wd_tick, wd_halt, wd_ovf;
  assign wd_en = sys_opt[`RWC_OPT_EN] & cpu_run;
  assign wd_tick = wd_clks ? bus_tick : slow_tick;
  // The stop exit cycle itself counts nothing; the resume delay follows
  assign wd_halt = bdm_active | stop_mode | (stop_d & ~stop_mode);
  assign wd_ovf = wd_en & ~wd_halt & wd_tick & (resume_cnt == 2'h0) &
                  (wd_cnt == CNT_W'((1 << ovf_exp(wd_clks, wd_t)) - 1));

  // Temperature back in range with restart armed
  logic temp_restart;
  assign temp_restart = temp_restart_enable & tout_d & ~tout_s2;

  // Any source that restarts the system
  logic any_reset;
  assign any_reset = cause_req.low_voltage_detect |
                     cause_req.illegal_op | cause_req.illegal_addr |
                     cause_req.debug | cause_req.periodic | wd_ovf |
                     temp_restart;

  // Reset sequencer
  always_ff @(posedge clk) begin
    if (srst || any_reset) begin
      state <= RWC_HOLD;
      hold_cnt <= '0;
    end else begin
      unique case (state)
        RWC_HOLD: begin
          hold_cnt <= hold_cnt + 4'h1;
          if (hold_cnt == HOLD_CYC - 4'h1) begin
            state <= RWC_REQ_HI;
          end
        end
        RWC_REQ_HI: state <= RWC_REQ_LO;
        RWC_REQ_LO: state <= RWC_DONE;
        RWC_DONE: state <= RWC_RUN;
        RWC_RUN: state <= RWC_RUN;
      endcase
    end
  end

  // Vector fetch and boot outputs
  always_ff @(posedge clk) begin
    if (srst || any_reset) begin
      vec_addr <= `RWC_VEC_HI_ADDR;
      vec_rd <= 1'b0;
      sys_reset <= 1'b1;
      cpu_run <= 1'b0;
      boot.pc <= '0;
      boot.stack_pointer <= `RWC_STACK_INIT;
      boot.imask <= 1'b1;
      boot.periph_off <= 1'b1;
      boot.pin_oe <= 1'b0;
      boot.pullup_en <= 1'b0;
    end else begin
      vec_rd <= 1'b0;
      if (state == RWC_HOLD && hold_cnt == HOLD_CYC - 4'h1) begin
        vec_addr <= `RWC_VEC_HI_ADDR;
        vec_rd <= 1'b1;
      end
      if (state == RWC_REQ_HI) begin
        vec_addr <= `RWC_VEC_LO_ADDR;
        vec_rd <= 1'b1;
      end
      if (state == RWC_REQ_LO) begin
        boot.pc[15:8] <= vec_rdata;
      end
      if (state == RWC_DONE) begin
        boot.pc[7:0] <= vec_rdata;
        sys_reset <= 1'b0;
        cpu_run <= 1'b1;
      end
    end
  end

  // Reset cause register shows only the latest recorded source; debug,
  // periodic and temperature restarts leave it as it was
  logic cause_rec;
  assign cause_rec = cause_req.low_voltage_detect | cause_req.illegal_op |
                     cause_req.illegal_addr | wd_ovf;
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_cause <= 8'h00;
      reset_cause[`RWC_RC_POR] <= 1'b1;
    end else if (cause_rec) begin
      reset_cause <= 8'h00;
      reset_cause[`RWC_RC_LOW_VOLT] <= cause_req.low_voltage_detect;
      reset_cause[`RWC_RC_WDOG] <= wd_ovf;
      reset_cause[`RWC_RC_ILOP] <= cause_req.illegal_op;
      reset_cause[`RWC_RC_ILAD] <= cause_req.illegal_addr;
    end
  end

  // Periodic reset flag; a new event wins over a clear
  always_ff @(posedge clk) begin
    if (srst) begin
      periodic_reset_flag <= 1'b0;
    end else if (cause_req.periodic) begin
      periodic_reset_flag <= 1'b1;
    end else if (wr_wcs && pwdata[`RWC_WCS_PERIODIC]) begin
      periodic_reset_flag <= 1'b0;
    end
  end

  // Restart enable can only be armed while outside the range
  always_ff @(posedge clk) begin
    tout_d <= tout_s2;
    if (srst || any_reset) begin
      temp_restart_enable <= 1'b0;
    end else if (!tout_s2) begin
      temp_restart_enable <= 1'b0;
    end else if (wr_wcs) begin
      temp_restart_enable <= pwdata[`RWC_WCS_RESTART_EN];
    end
  end

  // Option register: any reset restores defaults and unlocks
  always_ff @(posedge clk) begin
    if (srst || any_reset) begin
      sys_opt <= `RWC_OPT_RESET;
      opt_locked <= 1'b0;
    end else if (wr_opt && !opt_locked) begin
      sys_opt <= pwdata[7:0];
      opt_locked <= 1'b1;
    end
  end

  // Temperature restart register; trim bits are stored as written
  always_ff @(posedge clk) begin
    if (srst) begin
      temp_reg <= `RWC_TEMP_RESET;
    end else if (wr_temp) begin
      temp_reg <= pwdata[7:0];
    end
  end

  // Watchdog counter. Settings are sampled only when it clears, so a
  // late option write never mixes old and new limits.
  logic wd_clear;
  assign wd_clear = wr_cause | (stop_mode & ~stop_d) | ~wd_en;
  always_ff @(posedge clk) begin
    stop_d <= stop_mode;
    if (srst || any_reset) begin
      wd_cnt <= '0;
      wd_clks <= OPT_DEF[`RWC_OPT_CLKS];
      wd_t <= OPT_DEF[`RWC_OPT_T_HI:`RWC_OPT_T_LO];
      resume_cnt <= 2'h0;
    end else begin
      if (wd_clear) begin
        wd_cnt <= '0;
        wd_clks <= sys_opt[`RWC_OPT_CLKS];
        wd_t <= sys_opt[`RWC_OPT_T_HI:`RWC_OPT_T_LO];
      end else if (wd_en && !wd_halt && wd_tick &&
                   resume_cnt == 2'h0) begin
        wd_cnt <= wd_cnt + CNT_W'(1);
      end
      if (stop_d && !stop_mode && wd_en) begin
        resume_cnt <= `RWC_RESUME_TICKS;
      end else if (resume_cnt != 2'h0 && wd_tick && !wd_halt) begin
        resume_cnt <= resume_cnt - 2'h1;
      end
    end
  end

  // APB slave: one wait state, registered answer
  logic hit;
  assign hit = addr_is(paddr, `RWC_IDX_RESET_CAUSE) |
               addr_is(paddr, `RWC_IDX_SYS_OPT_ONE) |
               addr_is(paddr, `RWC_IDX_WAKE_CS_ONE) |
               addr_is(paddr, `RWC_IDX_TEMP_RESTART);
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      prdata <= 32'h0;
      if (acc && !pready && !pwrite) begin
        if (addr_is(paddr, `RWC_IDX_RESET_CAUSE)) begin
          prdata[7:0] <= reset_cause;
        end
        if (addr_is(paddr, `RWC_IDX_SYS_OPT_ONE)) begin
          prdata[7:0] <= sys_opt;
        end
        if (addr_is(paddr, `RWC_IDX_WAKE_CS_ONE)) begin
          prdata[`RWC_WCS_PERIODIC] <= periodic_reset_flag;
          prdata[`RWC_WCS_RESTART_EN] <= temp_restart_enable;
        end
        if (addr_is(paddr, `RWC_IDX_TEMP_RESTART)) begin
          prdata[7:1] <= temp_reg[7:1];
          prdata[`RWC_TEMP_OUTSIDE] <= tout_s2;
        end
      end
    end
  end

endmodule : rwc_top

// ===== logic/rwc_defs.svh
// Offsets, field positions, reset values and counts for reset/watchdog control
`ifndef RWC_DEFS_SVH
`define RWC_DEFS_SVH

// Register indices; byte address is four times the index
`define RWC_IDX_RESET_CAUSE 16'h1800
`define RWC_IDX_SYS_OPT_ONE 16'h1802
`define RWC_IDX_WAKE_CS_ONE 16'h1804
`define RWC_IDX_TEMP_RESTART 16'h180f

// Reset cause register bit positions
`define RWC_RC_POR 7
`define RWC_RC_WDOG 5
`define RWC_RC_ILOP 4
`define RWC_RC_ILAD 3
`define RWC_RC_LOW_VOLT 1

// System option one fields
`define RWC_OPT_EN 7
`define RWC_OPT_CLKS 6
`define RWC_OPT_T_HI 2
`define RWC_OPT_T_LO 0
`define RWC_OPT_RESET 8'h87

// Wakeup control/status one fields
`define RWC_WCS_PERIODIC 7
`define RWC_WCS_RESTART_EN 1

// Temperature restart register
`define RWC_TEMP_RESET 8'h39
`define RWC_TEMP_THRESH_HI 6
`define RWC_TEMP_THRESH_LO 4
`define RWC_TEMP_OUTSIDE 0

// Boot values
`define RWC_VEC_HI_ADDR 16'hdffe
`define RWC_VEC_LO_ADDR 16'hdfff
`define RWC_STACK_INIT 16'h00ff

// Watchdog overflow exponents and restart delay
`define RWC_EXP_SLOW_BASE 5'h05
`define RWC_EXP_BUS_BASE 5'h0d
`define RWC_RESUME_TICKS 2'h3

// Cycles the system reset is held before the vector fetch
`define RWC_RESET_HOLD 4'h8

`endif

// ===== logic/rwc_pkg.sv
// Types for the reset and watchdog control block
package rwc_pkg;

  typedef enum logic [2:0] {
    RWC_HOLD,
    RWC_REQ_HI,
    RWC_REQ_LO,
    RWC_DONE,
    RWC_RUN
  } rwc_state_type;

  // Reset requests from other logic, one-cycle pulses
  typedef struct packed {
    logic low_voltage_detect;
    logic illegal_op;
    logic illegal_addr;
    logic debug;
    logic periodic;
  } rwc_cause_type;

  // Boot-time state driven to the core and pads
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] stack_pointer;
    logic imask;
    logic periph_off;
    logic pin_oe;
    logic pullup_en;
  } rwc_boot_type;

endpackage : rwc_pkg

// ===== sim/rwc_monitor.sv
// Concurrent checks on the reset and watchdog block ports
`timescale 1ns/1ps
module rwc_monitor #(
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sequencer
  input wire rwc_pkg::rwc_cause_type cause_req,
  input wire logic [15:0] vec_addr,
  input wire logic vec_rd,
  input wire logic sys_reset,
  input wire logic cpu_run,
  input wire rwc_pkg::rwc_boot_type boot
);
  import rwc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ready_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  boot_stack_a: assert property (sys_reset |->
    boot.stack_pointer == 16'h00ff)
    else $error("stack pointer wrong");
  boot_mask_a: assert property (sys_reset |-> boot.imask)
    else $error("mask clear in reset");
  boot_pins_a: assert property (sys_reset |->
    boot.periph_off && !boot.pin_oe && !boot.pullup_en)
    else $error("pads active in reset");
  vec_order_a: assert property (vec_rd && vec_addr == 16'hdffe |->
    ##[1:4] vec_rd && vec_addr == 16'hdfff)
    else $error("low vector byte missing");
  run_start_a: assert property ($rose(cpu_run) |-> $past(sys_reset))
    else $error("run without sequence");
  cause_rst_a: assert property (
    cause_req.low_voltage_detect || cause_req.illegal_op |->
    ##[1:3] sys_reset)
    else $error("cause ignored");
endmodule : rwc_monitor

bind rwc_top rwc_monitor #(.CNT_W(CNT_W)) mon (.clk(clk), .srst(srst),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cause_req(cause_req), .vec_addr(vec_addr),
  .vec_rd(vec_rd), .sys_reset(sys_reset), .cpu_run(cpu_run), .boot(boot));

// ===== sim/tb_reset_and_watchdog_control.sv
// Self-checking bench for the reset and watchdog block
`timescale 1ns/1ps
module tb_reset_and_watchdog_control;
  import rwc_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, q;
  rwc_cause_type cause_req;
  logic bdm_active, stop_mode, bus_tick, slow_clk_pin, temp_outside_pin;
  logic slow_run;
  logic [15:0] vec_addr;
  logic [7:0] vec_rdata;
  logic vec_rd, sys_reset, cpu_run;
  rwc_boot_type boot;
  int mismatches, n_compared, n;

  rwc_top uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cause_req(cause_req),
    .bdm_active(bdm_active), .stop_mode(stop_mode), .bus_tick(bus_tick),
    .slow_clk_pin(slow_clk_pin), .temp_outside_pin(temp_outside_pin),
    .vec_addr(vec_addr), .vec_rd(vec_rd), .vec_rdata(vec_rdata),
    .sys_reset(sys_reset), .cpu_run(cpu_run), .boot(boot));

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // Slow oscillator pin toggles every cycle while enabled
  always @(posedge clk) begin
    slow_clk_pin <= slow_run & ~slow_clk_pin;
  end
  // Vector data only valid after a fetch; otherwise it keeps toggling
  always @(posedge clk) begin
    vec_rdata <= vec_rd ? (vec_addr == 16'hdffe ? 8'hc3 : 8'h5a) : ~vec_rdata;
  end

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb

  task automatic wait_rst(input int lim);
    n = 0;
    while (sys_reset !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_rst

  task automatic wait_run;
    n = 0;
    while (cpu_run !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("cpu_run", 1, cpu_run);
  endtask : wait_run

  task automatic t_boot;
    chk("sys_reset", 1, sys_reset);
    chk("stack pointer", 32'h00ff, boot.stack_pointer);
    chk("imask", 1, boot.imask);
    chk("pads", 3'b100, {boot.periph_off, boot.pin_oe, boot.pullup_en});
    wait_run;
    chk("pc", 32'hc35a, boot.pc);
  endtask : t_boot

  task automatic t_regs;
    apb(0, 32'h6000, 0);
    chk("cause", 32'h80, q);
    apb(0, 32'h6008, 0);
    chk("option", 32'h87, q);
    apb(0, 32'h603c, 0);
    chk("temp", 32'h39, q);
    temp_outside_pin <= 0;
    repeat (4) @(posedge clk);
    // Trim bits written back unchanged
    apb(1, 32'h603c, 32'h69);
    apb(0, 32'h603c, 0);
    chk("temp", 32'h68, q);
    apb(0, 32'h7000, 0);
    chk("pslverr", 1, e);
    chk("prdata", 0, q);
  endtask : t_regs

  task automatic t_wdog;
    apb(1, 32'h6008, 32'hc0);
    apb(1, 32'h6008, 32'h00);
    apb(0, 32'h6008, 0);
    chk("option", 32'hc0, q);
    for (int i = 0; i < 3; i++) begin
      apb(1, 32'h6000, 32'h5a);
      wait_rst(6000);
      chk("serviced", 6000, n);
    end
    apb(0, 32'h6000, 0);
    chk("cause", 32'h80, q);
    stop_mode <= 1;
    wait_rst(10000);
    chk("stopped", 10000, n);
    stop_mode <= 0;
    wait_rst(8400);
    chk("span", 1, n >= 8190 && n <= 8205);
    wait_run;
    apb(0, 32'h6000, 0);
    chk("cause", 32'h20, q);
  endtask : t_wdog

  task automatic t_cause(input rwc_cause_type c, input logic [31:0] x);
    cause_req <= c;
    @(posedge clk);
    cause_req <= '0;
    wait_rst(5);
    wait_run;
    apb(0, 32'h6000, 0);
    chk("cause", x, q);
  endtask : t_cause

  task automatic t_temp;
    apb(1, 32'h6010, 32'h02);
    apb(0, 32'h6010, 0);
    chk("wakeup", 32'h80, q);
    temp_outside_pin <= 1;
    repeat (4) @(posedge clk);
    apb(1, 32'h6010, 32'h82);
    apb(0, 32'h6010, 0);
    chk("wakeup", 32'h02, q);
    temp_outside_pin <= 0;
    wait_rst(10);
    chk("restart", 1, n < 10);
    wait_run;
    apb(0, 32'h6000, 0);
    chk("cause", 32'h08, q);
  endtask : t_temp

  task automatic t_slow;
    apb(1, 32'h6008, 32'h80);
    apb(1, 32'h6000, 0);
    slow_run <= 1;
    bdm_active <= 1;
    wait_rst(300);
    chk("debug halt", 300, n);
    bdm_active <= 0;
    wait_rst(300);
    chk("slow span", 1, n >= 60 && n <= 70);
    slow_run <= 0;
    wait_run;
    apb(0, 32'h6000, 0);
    chk("cause", 32'h20, q);
  endtask : t_slow

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    mismatches = 0;
    n_compared = 0;
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 67'h0};
    {cause_req, bdm_active, stop_mode, slow_clk_pin, slow_run} = '0;
    {bus_tick, temp_outside_pin, vec_rdata} = {2'b11, 8'h00};
    repeat (4) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    t_boot;
    t_regs;
    t_wdog;
    t_cause(5'b10000, 32'h02);
    t_cause(5'b01000, 32'h10);
    t_cause(5'b00100, 32'h08);
    t_cause(5'b00010, 32'h08);
    t_cause(5'b00001, 32'h08);
    apb(0, 32'h6010, 0);
    chk("wakeup", 32'h80, q);
    t_temp;
    t_slow;
    report_and_stop;
  end

  initial begin
    #300000;
    mismatches++;
    report_and_stop;
  end
endmodule : tb_reset_and_watchdog_control
